// ---- hdl/vtp_pkg.sv ----
// shared constants and types for the video test pattern and self-test block
package vtp_pkg;

  // ****************************************
  // register map and field layout
  // ****************************************
  localparam logic [9:0] REG_TEST_CONTROL_ADDR = 10'h00D;
  localparam int         TC_PASS_BIT           = 7;
  localparam int         TC_ENABLE_BIT         = 6;
  localparam logic [9:0] TC_RESET_VALUE        = 10'h000;  // black, 525/27 MHz, SD 270
  localparam int         PORT_INIT_CYCLES      = 3;

  // pattern code fields
  localparam int         PAT_TYPE_LSB = 0;     // two bits of pattern type
  localparam int         PAT_PAL_BIT  = 2;
  localparam int         PAT_HD_BIT   = 5;

  // raster defaults, counts of parallel words
  localparam int         SAMPLES_PER_LINE_DEF = 1716;
  localparam int         LINES_PER_FIELD_DEF  = 263;
  localparam int         FIELDS_TO_PASS       = 2;
  localparam int         BAR_COUNT            = 8;

  // blanking and pathological words
  localparam logic [9:0] WORD_CHROMA_ZERO = 10'h200;
  localparam logic [9:0] WORD_LUMA_BLACK  = 10'h040;
  localparam logic [9:0] WORD_PLL_CHROMA  = 10'h200;
  localparam logic [9:0] WORD_PLL_LUMA    = 10'h110;
  localparam logic [9:0] WORD_EQ_CHROMA   = 10'h300;
  localparam logic [9:0] WORD_EQ_LUMA     = 10'h198;

  // check-word polynomials (feedback taps without the top term)
  localparam logic [15:0] SD_POLY = 16'h1041;      // x16 + x12 + x6 + 1
  localparam logic [17:0] HD_POLY = 18'h0_0031;    // x18 + x5 + x4 + 1

  typedef enum logic [1:0] {
    VTP_PAT_BLACK,
    VTP_PAT_PLL,
    VTP_PAT_EQ,
    VTP_PAT_BARS
  } vtp_pat_type_t;

  // test control register as seen by software
  typedef struct packed {
    logic [1:0] rateSel;
    logic       passFail;
    logic       runEnable;
    logic [5:0] patternSelect;
  } vtp_test_ctrl_t;

  // one word captured at the control port
  typedef struct packed {
    logic       isData;
    logic [9:0] word;
  } vtp_port_word_t;

endpackage

// ---- hdl/vtp_self_test.sv ----
// video test pattern generator with go/no-go self-test and control port
//
// Behaviour
// - four patterns: black, PLL pathological, EQ pathological, 75% eight colour bars
// - bar transitions are smoothed only when the bar filter enable is set; off by default
// - self-test accepts HD bars, SD NTSC bars or SD PAL PLL pathological
// - self-test feeds pattern into input register, through datapath, checks with check words
// - pass/fail lives in test control register and drives an I/O output
// - default mapping takes the run enable from I/O port bit 7
// - generator runs when enable comes from I/O pin or register bit
// - under default mapping a low pin overrides a written register enable
// - pass goes high after two clean fields; any error keeps it low
// - dropping the enable stops generation and self-test
// - serial output carries generated data while running
// - after reset the pattern code is 00h, SD black
// - code 303h selects NTSC 525-line colour bars
// - pass/fail on I/O bit 6 and read back as register bit 7
// - register functions may be mapped onto the multifunction I/O bus
// - positive logic control bits; error flags cleared after reset
module vtp_self_test
  import vtp_pkg::*;
#(
  parameter int SAMPLES_PER_LINE = SAMPLES_PER_LINE_DEF,
  parameter int LINES_PER_FIELD  = LINES_PER_FIELD_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       portClk,
  input  wire logic       portSelect_b,
  input  wire logic       rdWr,
  input  wire logic [9:0] adIn,
  output logic      [9:0] adOut,
  output logic            adOe,
  input  wire logic       ioDefaultMap,
  input  wire logic       ioRunEnablePin,
  input  wire logic       barFilterEnable,
  output logic            ioPassFail,
  output logic      [9:0] serialOutData,
  output logic            serialOutValid
);

  // ****************************************
  // helper functions
  // ****************************************

  // one parallel word into the check word: 18-bit HD form, or 16-bit SD form in the low bits
  function automatic logic [17:0] crcStep(input logic [17:0] crc, input logic [9:0] word, input logic hd);
    logic [17:0] c;
    c = crc;
    for (int i = 0; i < 10; i++) begin
      c = hd ? ({c[16:0], 1'b0} ^ ((c[17] ^ word[i]) ? HD_POLY : 18'h0_0000)) :
               ({2'b00, c[14:0], 1'b0} ^ ((c[15] ^ word[i]) ? {2'b00, SD_POLY} : 18'h0_0000));
    end
    return c;
  endfunction

  // 75% bar word for bar index and component (0 Cb, 1 Y, 2 Cr)
  function automatic logic [9:0] barWord(input logic [2:0] bar, input logic [1:0] comp);
    logic [29:0] ycc;
    case (bar)
      3'd0:    ycc = {10'h2D0, 10'h200, 10'h200};   // white
      3'd1:    ycc = {10'h288, 10'h0B0, 10'h238};   // yellow
      3'd2:    ycc = {10'h20C, 10'h270, 10'h0B0};   // cyan
      3'd3:    ycc = {10'h1C0, 10'h120, 10'h0E8};   // green
      3'd4:    ycc = {10'h150, 10'h2E0, 10'h318};   // magenta
      3'd5:    ycc = {10'h104, 10'h190, 10'h350};   // red
      3'd6:    ycc = {10'h08C, 10'h350, 10'h1C8};   // blue
      default: ycc = {10'h040, 10'h200, 10'h200};   // black
    endcase
    return comp[0] ? ycc[29:20] : (comp[1] ? ycc[9:0] : ycc[19:10]);
  endfunction

  // ****************************************
  // control port on the port clock
  // ****************************************
  logic [1:0]     portRstSync_r;
  logic [1:0]     initCnt_r, initCnt_nxt;
  logic           phaseData_r, phaseData_nxt;
  vtp_port_word_t addrHold_r, addrHold_nxt;
  vtp_port_word_t dataHold_r, dataHold_nxt;
  logic           addrTgl_r, addrTgl_nxt;
  logic           dataTgl_r, dataTgl_nxt;
  logic           portWrite;

  // core reset brought into the port domain
  always_ff @(posedge portClk) begin
    portRstSync_r <= {portRstSync_r[0], rst_b};
  end

  assign portWrite = !portSelect_b && !rdWr && (initCnt_r == 2'(PORT_INIT_CYCLES));

  // first three clocks only prime the port, then address and data alternate
  always_comb begin
    initCnt_nxt   = initCnt_r;
    phaseData_nxt = phaseData_r;
    addrHold_nxt  = addrHold_r;
    dataHold_nxt  = dataHold_r;
    addrTgl_nxt   = addrTgl_r;
    dataTgl_nxt   = dataTgl_r;
    if (initCnt_r != 2'(PORT_INIT_CYCLES)) begin
      initCnt_nxt = initCnt_r + 2'd1;
    end else if (portWrite && !phaseData_r) begin
      addrHold_nxt  = '{isData: 1'b0, word: adIn};
      addrTgl_nxt   = !addrTgl_r;
      phaseData_nxt = 1'b1;
    end else if (portWrite) begin
      dataHold_nxt  = '{isData: 1'b1, word: adIn};
      dataTgl_nxt   = !dataTgl_r;
      phaseData_nxt = 1'b0;
    end else if (!portSelect_b && rdWr) begin
      phaseData_nxt = 1'b0;                        // read turnaround edge re-arms the address phase
    end
  end

  always_ff @(posedge portClk) begin
    if (!portRstSync_r[1]) begin
      initCnt_r   <= 2'd0;
      phaseData_r <= 1'b0;
      addrHold_r  <= '0;
      dataHold_r  <= '0;
      addrTgl_r   <= 1'b0;
      dataTgl_r   <= 1'b0;
    end else begin
      initCnt_r   <= initCnt_nxt;
      phaseData_r <= phaseData_nxt;
      addrHold_r  <= addrHold_nxt;
      dataHold_r  <= dataHold_nxt;
      addrTgl_r   <= addrTgl_nxt;
      dataTgl_r   <= dataTgl_nxt;
    end
  end

  // ****************************************
  // crossings into the core clock
  // ****************************************
  logic [2:0] addrTglSync_r;
  logic [2:0] dataTglSync_r;
  logic [1:0] selSync_r, rdSync_r, mapSync_r, pinSync_r, filtSync_r;

  // toggles keep a third stage for edge detection; levels use two flops
  always_ff @(posedge core_clk) begin
    addrTglSync_r <= {addrTglSync_r[1:0], addrTgl_r};
    dataTglSync_r <= {dataTglSync_r[1:0], dataTgl_r};
    selSync_r     <= {selSync_r[0], portSelect_b};
    rdSync_r      <= {rdSync_r[0], rdWr};
    mapSync_r     <= {mapSync_r[0], ioDefaultMap};
    pinSync_r     <= {pinSync_r[0], ioRunEnablePin};
    filtSync_r    <= {filtSync_r[0], barFilterEnable};
  end

  // ****************************************
  // core control, pattern generator and self-test
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PASS, ST_FAIL} vtp_state_t;

  vtp_state_t     state_r, state_nxt;
  vtp_test_ctrl_t ctrl_r, ctrl_nxt;
  logic [9:0]     lastAddr_r, lastAddr_nxt;
  logic [10:0]    sampleCnt_r, sampleCnt_nxt;
  logic [9:0]     lineCnt_r, lineCnt_nxt;
  logic [1:0]     fieldCnt_r, fieldCnt_nxt;
  logic [9:0]     prevWord_r [4];
  logic [9:0]     prevWord_nxt [4];
  logic [9:0]     inReg_r, inReg_nxt;          // input data register
  logic [9:0]     outReg_r, outReg_nxt;
  logic [9:0]     refReg_r, refReg_nxt;
  logic           pipeValid_r, pipeValid_nxt;
  logic [17:0]    refCrc_r, refCrc_nxt;
  logic [17:0]    chkCrc_r, chkCrc_nxt;
  logic [9:0]     adOut_nxt;
  logic           adOe_nxt;
  logic           running;
  logic           runEnable;
  logic           testable;
  logic           fieldEnd;
  logic [9:0]     genWord;
  logic [2:0]     barIdx;
  vtp_pat_type_t  patType;

  assign patType  = vtp_pat_type_t'(ctrl_r.patternSelect[PAT_TYPE_LSB +: 2]);
  // default map: the pin alone decides, so a low pin beats the register bit
  assign runEnable = mapSync_r[1] ? pinSync_r[1] : ctrl_r.runEnable;
  assign running   = (state_r != ST_IDLE);
  assign testable  = (patType == VTP_PAT_BARS && (ctrl_r.patternSelect[PAT_HD_BIT] ||
                      !ctrl_r.patternSelect[PAT_PAL_BIT])) ||
                     (patType == VTP_PAT_PLL && !ctrl_r.patternSelect[PAT_HD_BIT] &&
                      ctrl_r.patternSelect[PAT_PAL_BIT]);
  assign fieldEnd  = (sampleCnt_r == 11'(SAMPLES_PER_LINE - 1)) && (lineCnt_r == 10'(LINES_PER_FIELD - 1));
  assign barIdx    = 3'((32'(sampleCnt_r) * BAR_COUNT) / SAMPLES_PER_LINE);

  // pattern word for the current sample, chroma on even samples
  always_comb begin
    logic       isLuma;
    logic [1:0] comp;
    logic [9:0] raw;
    raw    = 10'h000;
    isLuma = sampleCnt_r[0];
    comp   = isLuma ? 2'd1 : (sampleCnt_r[1] ? 2'd2 : 2'd0);
    case (patType)
      VTP_PAT_BLACK: raw = isLuma ? WORD_LUMA_BLACK : WORD_CHROMA_ZERO;
      VTP_PAT_PLL:   raw = isLuma ? WORD_PLL_LUMA : WORD_PLL_CHROMA;
      VTP_PAT_EQ:    raw = isLuma ? WORD_EQ_LUMA : WORD_EQ_CHROMA;
      default:       raw = barWord(barIdx, comp);
    endcase
    // soften bar edges by averaging with the previous word of the same component
    if (patType == VTP_PAT_BARS && filtSync_r[1]) begin
      genWord = 10'((11'(raw) + 11'(prevWord_r[comp])) >> 1);
    end else begin
      genWord = raw;
    end
  end

  // next state of register, raster, datapath and checker
  always_comb begin
    state_nxt     = state_r;
    ctrl_nxt      = ctrl_r;
    lastAddr_nxt  = lastAddr_r;
    sampleCnt_nxt = sampleCnt_r;
    lineCnt_nxt   = lineCnt_r;
    fieldCnt_nxt  = fieldCnt_r;
    prevWord_nxt  = prevWord_r;
    inReg_nxt     = inReg_r;
    outReg_nxt    = outReg_r;
    refReg_nxt    = refReg_r;
    pipeValid_nxt = 1'b0;
    refCrc_nxt    = refCrc_r;
    chkCrc_nxt    = chkCrc_r;
    // host words arriving from the port
    if (addrTglSync_r[2] != addrTglSync_r[1]) begin
      lastAddr_nxt = addrHold_r.word;
    end
    if (dataTglSync_r[2] != dataTglSync_r[1] && lastAddr_r == REG_TEST_CONTROL_ADDR) begin
      ctrl_nxt.rateSel       = dataHold_r.word[9:8];
      ctrl_nxt.runEnable     = dataHold_r.word[TC_ENABLE_BIT];
      ctrl_nxt.patternSelect = dataHold_r.word[5:0];
    end
    case (state_r)
      ST_IDLE: begin
        sampleCnt_nxt = '0;
        lineCnt_nxt   = '0;
        fieldCnt_nxt  = '0;
        refCrc_nxt    = '0;
        chkCrc_nxt    = '0;
        if (runEnable) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        // raster walk and datapath run in every active state
        pipeValid_nxt = 1'b1;
        inReg_nxt     = genWord;
        outReg_nxt    = inReg_r;
        refReg_nxt    = inReg_r;                                         // reference taps the input register
        prevWord_nxt[{!sampleCnt_r[0] & sampleCnt_r[1], sampleCnt_r[0]}] = genWord;
        if (sampleCnt_r == 11'(SAMPLES_PER_LINE - 1)) begin
          sampleCnt_nxt = '0;
          lineCnt_nxt   = fieldEnd ? '0 : lineCnt_r + 10'd1;
        end else begin
          sampleCnt_nxt = sampleCnt_r + 11'd1;
        end
        // check words: SD word for standard definition, HD word otherwise
        refCrc_nxt = crcStep(refCrc_r, refReg_r, ctrl_r.patternSelect[PAT_HD_BIT]);
        chkCrc_nxt = crcStep(chkCrc_r, outReg_r, ctrl_r.patternSelect[PAT_HD_BIT]);
        if (fieldEnd) begin
          refCrc_nxt = '0;
          chkCrc_nxt = '0;
          if (state_r == ST_RUN) begin
            if (refCrc_r != chkCrc_r || !testable) begin
              state_nxt = ST_FAIL;
            end else if (fieldCnt_r == 2'(FIELDS_TO_PASS - 1)) begin
              state_nxt = ST_PASS;
            end else begin
              fieldCnt_nxt = fieldCnt_r + 2'd1;
            end
          end else if (state_r == ST_PASS && refCrc_r != chkCrc_r) begin
            state_nxt = ST_FAIL;
          end
        end
        if (!runEnable) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    ctrl_nxt.passFail = (state_nxt == ST_PASS);
    // register read back while the host holds select low and direction high
    adOe_nxt  = !selSync_r[1] && rdSync_r[1];
    adOut_nxt = (lastAddr_r == REG_TEST_CONTROL_ADDR) ? ctrl_r : 10'h000;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r        <= ST_IDLE;
      ctrl_r         <= TC_RESET_VALUE;
      lastAddr_r     <= '0;
      sampleCnt_r    <= '0;
      lineCnt_r      <= '0;
      fieldCnt_r     <= '0;
      prevWord_r     <= '{default: '0};
      inReg_r        <= '0;
      outReg_r       <= '0;
      refReg_r       <= '0;
      pipeValid_r    <= 1'b0;
      refCrc_r       <= '0;
      chkCrc_r       <= '0;
      adOut          <= '0;
      adOe           <= 1'b0;
      ioPassFail     <= 1'b0;
      serialOutData  <= '0;
      serialOutValid <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      ctrl_r         <= ctrl_nxt;
      lastAddr_r     <= lastAddr_nxt;
      sampleCnt_r    <= sampleCnt_nxt;
      lineCnt_r      <= lineCnt_nxt;
      fieldCnt_r     <= fieldCnt_nxt;
      prevWord_r     <= prevWord_nxt;
      inReg_r        <= inReg_nxt;
      outReg_r       <= outReg_nxt;
      refReg_r       <= refReg_nxt;
      pipeValid_r    <= pipeValid_nxt;
      refCrc_r       <= refCrc_nxt;
      chkCrc_r       <= chkCrc_nxt;
      adOut          <= adOut_nxt;
      adOe           <= adOe_nxt;
      ioPassFail     <= ctrl_nxt.passFail;
      serialOutData  <= (running && pipeValid_r) ? outReg_r : '0;
      serialOutValid <= running && pipeValid_r;
    end
  end

endmodule

// ---- testbench/tb.sv ----
// top-level self-checking testbench for the video test pattern self-test block
module tb
  import vtp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] TC = REG_TEST_CONTROL_ADDR;
  logic       core_clk;
  logic       rst_b;
  logic       portClk;
  logic       portSelect_b;
  logic       rdWr;
  logic [9:0] adIn;
  logic [9:0] adOut;
  logic       adOe;
  logic       ioDefaultMap;
  logic       ioRunEnablePin;
  logic       barFilterEnable;
  logic       ioPassFail;
  logic [9:0] serialOutData;
  logic       serialOutValid;
  int         fails;
  int         checks;

  vtp_self_test #(.SAMPLES_PER_LINE(16), .LINES_PER_FIELD(4)) i_vtp_self_test (
    .core_clk        (core_clk),
    .rst_b           (rst_b),
    .portClk         (portClk),
    .portSelect_b    (portSelect_b),
    .rdWr            (rdWr),
    .adIn            (adIn),
    .adOut           (adOut),
    .adOe            (adOe),
    .ioDefaultMap    (ioDefaultMap),
    .ioRunEnablePin  (ioRunEnablePin),
    .barFilterEnable (barFilterEnable),
    .ioPassFail      (ioPassFail),
    .serialOutData   (serialOutData),
    .serialOutValid  (serialOutValid)
  );
  vtp_host_model i_vtp_host_model (
    .portClk      (portClk),
    .portSelect_b (portSelect_b),
    .rdWr         (rdWr),
    .adIn         (adIn)
  );

  // fixed 125 MHz core clock (8 ns period), above the 27 MHz rate the pattern expects
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****************
  // shared tasks
  // ****************
  task automatic cmp(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [9:0] d);
    i_vtp_host_model.writeReg(a, d);
    cyc(6);
  endtask
  // loads the address, turns the port round, checks what the device drives back
  task automatic rdChk(input logic [9:0] a, input logic [9:0] exp);
    i_vtp_host_model.startRead(a);
    for (int i = 0; i < 12 && adOe !== 1'b1; i++) cyc(1);
    cyc(1);                                                 // address crossing may trail the turnaround
    cmp("adOe", 10'h001, 10'(adOe));
    cmp("adOut", exp, adOut);
    i_vtp_host_model.endRead();
    cyc(4);
  endtask
  task automatic waitPass(input int n);
    for (int i = 0; i < n && ioPassFail !== 1'b1; i++) cyc(1);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic tResetState();
    rdChk(TC, TC_RESET_VALUE);
    cmp("ioPassFail", 10'h000, 10'(ioPassFail));
    cmp("serialOutValid", 10'h000, 10'(serialOutValid));
  endtask
  // bars chosen over the port, run from the pin, stopped by dropping it
  task automatic tPinBars();
    wr(TC, 10'h303);
    rdChk(TC, 10'h303);
    ioRunEnablePin = 1'b1;
    cyc(8);
    cmp("serialOutValid", 10'h001, 10'(serialOutValid));
    cyc(90);
    cmp("early ioPassFail", 10'h000, 10'(ioPassFail));
    waitPass(60);
    cmp("ioPassFail", 10'h001, 10'(ioPassFail));
    rdChk(TC, 10'h383);
    ioRunEnablePin = 1'b0;
    cyc(6);
    cmp("stopped ioPassFail", 10'h000, 10'(ioPassFail));
    cmp("stopped serialOutData", 10'h000, serialOutData);
  endtask
  // register enable held off by the low pin, then run once the pin is unmapped
  task automatic tOverride();
    wr(TC, 10'h343);
    cyc(20);
    cmp("overridden run", 10'h000, 10'(serialOutValid));
    ioDefaultMap = 1'b0;
    cyc(8);
    cmp("register run", 10'h001, 10'(serialOutValid));
    waitPass(170);
    rdChk(TC, 10'h3c3);
    wr(TC, 10'h303);
    cmp("register stop", 10'h000, 10'(serialOutValid));
  endtask
  // every pattern type, with and without self-test support
  task automatic tPatterns();
    logic [9:0] code [7] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h005, 10'h023, 10'h007};
    logic [9:0] luma [7] = '{WORD_LUMA_BLACK, WORD_PLL_LUMA, WORD_EQ_LUMA, 10'h2d0, WORD_PLL_LUMA, 10'h2d0, 10'h2d0};
    logic [6:0] passExp = 7'b0111000;
    logic       seen;
    for (int k = 0; k < 7; k++) begin
      seen = 1'b0;
      wr(TC, code[k] | 10'h040);
      for (int i = 0; i < 170; i++) begin
        cyc(1);
        if (serialOutData === luma[k]) seen = 1'b1;
      end
      cmp("pattern word seen", 10'h001, 10'(seen));
      cmp("self-test result", 10'(passExp[k]), 10'(ioPassFail));
      wr(TC, code[k]);
    end
  endtask
  // bars captured from a pin start with and without the edge filter
  task automatic tFilter();
    logic [9:0] plain [64];
    int         diff;
    diff         = 0;
    ioDefaultMap = 1'b1;
    wr(TC, 10'h303);
    for (int f = 0; f < 2; f++) begin
      barFilterEnable = f[0];
      cyc(4);
      ioRunEnablePin = 1'b1;
      for (int i = 0; i < 64; i++) begin
        cyc(1);
        if (f == 0) plain[i] = serialOutData;
        else if (i > 8 && plain[i] !== serialOutData) diff++;
      end
      ioRunEnablePin = 1'b0;
      cyc(6);
    end
    barFilterEnable = 1'b0;
    cmp("filtered bars differ", 10'h001, 10'(diff > 0));
  endtask
  task automatic tUnmapped();
    wr(10'h00e, 10'h3ff);
    rdChk(10'h00e, 10'h000);
    rdChk(TC, 10'h303);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    rst_b           = 1'b0;
    ioDefaultMap    = 1'b1;
    ioRunEnablePin  = 1'b0;
    barFilterEnable = 1'b0;
    fails           = 0;
    checks          = 0;
    i_vtp_host_model.tick(3);
    cyc(2);
    rst_b = 1'b1;
    i_vtp_host_model.tick(5);
    cyc(2);
    tResetState();
    tPinBars();
    tOverride();
    tPatterns();
    tFilter();
    tUnmapped();
    final_report();
  end

  // cuts a hang short
  initial begin
    repeat (12000) @(posedge core_clk);
    fails++;
    $display("[FAIL] watchdog expected finish seen timeout");
    final_report();
  end
endmodule

bind vtp_self_test vtp_checker #(
  .SAMPLES_PER_LINE (SAMPLES_PER_LINE),
  .LINES_PER_FIELD  (LINES_PER_FIELD)
) i_vtp_checker (
  .core_clk       (core_clk),
  .rst_b          (rst_b),
  .portSelect_b   (portSelect_b),
  .rdWr           (rdWr),
  .adOut          (adOut),
  .adOe           (adOe),
  .ioDefaultMap   (ioDefaultMap),
  .ioRunEnablePin (ioRunEnablePin),
  .ioPassFail     (ioPassFail),
  .serialOutData  (serialOutData),
  .serialOutValid (serialOutValid)
);

// ---- testbench/vtp_checker.sv ----
// assertion checker for the video test pattern self-test block
module vtp_checker
  import vtp_pkg::*;
#(
  parameter int SAMPLES_PER_LINE = 16,
  parameter int LINES_PER_FIELD  = 4
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       portSelect_b,
  input wire logic       rdWr,
  input wire logic [9:0] adOut,
  input wire logic       adOe,
  input wire logic       ioDefaultMap,
  input wire logic       ioRunEnablePin,
  input wire logic       ioPassFail,
  input wire logic [9:0] serialOutData,
  input wire logic       serialOutValid
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PASS_MIN = FIELDS_TO_PASS * SAMPLES_PER_LINE * LINES_PER_FIELD - 4;
  logic [15:0] runCnt_r;
  logic [15:0] runCnt_nxt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ****************
  // helper logic
  // ****************
  // cycles spent with valid output since the run began
  always_comb begin
    runCnt_nxt = (!rst_b || !serialOutValid) ? 16'h0000 : runCnt_r + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    runCnt_r <= runCnt_nxt;
  end

  // ****************
  // properties
  // ****************
  sequence s_pinOn;
    (ioDefaultMap && ioRunEnablePin) [*8];
  endsequence
  sequence s_pinOff;
    (ioDefaultMap && !ioRunEnablePin) [*8];
  endsequence
  sequence s_readReq;
    (!portSelect_b && rdWr) [*4];
  endsequence
  property p_resetClear;
    $rose(rst_b) |-> adOut == 10'h000 && !adOe && !ioPassFail && !serialOutValid;
  endproperty
  property p_pinRun;
    s_pinOn |-> serialOutValid;
  endproperty
  property p_pinOverride;
    s_pinOff |-> !serialOutValid;
  endproperty
  property p_pinStop;
    $fell(ioRunEnablePin) && ioDefaultMap |-> ##[1:6] !serialOutValid;
  endproperty
  property p_idleQuiet;
    !serialOutValid |-> serialOutData == 10'h000;
  endproperty
  property p_passWhileRun;
    $rose(ioPassFail) |-> serialOutValid;
  endproperty
  property p_passNotEarly;
    $rose(ioPassFail) |-> runCnt_r >= PASS_MIN;
  endproperty
  property p_passDrop;
    $fell(serialOutValid) |-> ##[0:1] !ioPassFail;
  endproperty
  property p_readDrive;
    s_readReq |-> adOe;
  endproperty
  property p_readRelease;
    portSelect_b [*4] |-> !adOe;
  endproperty

  a_resetClear: assert property (p_resetClear) else $error("outputs not clear after reset");
  a_pinRun: assert property (p_pinRun) else $error("pin enable did not start run");
  a_pinOverride: assert property (p_pinOverride) else $error("low pin did not hold idle");
  a_pinStop: assert property (p_pinStop) else $error("run kept going after enable drop");
  a_idleQuiet: assert property (p_idleQuiet) else $error("serial data not zero while idle");
  a_passWhileRun: assert property (p_passWhileRun) else $error("pass rose while idle");
  a_passNotEarly: assert property (p_passNotEarly) else $error("pass before two fields");
  a_passDrop: assert property (p_passDrop) else $error("pass kept after stop");
  a_readDrive: assert property (p_readDrive) else $error("port bus not driven on read");
  a_readRelease: assert property (p_readRelease) else $error("port bus driven while deselected");
endmodule

// ---- testbench/vtp_host_model.sv ----
// host controller model for the control port of the self-test block
module vtp_host_model (
  output logic       portClk,
  output logic       portSelect_b,
  output logic       rdWr,
  output logic [9:0] adIn
);
  timeunit 1ns;
  timeprecision 100ps;

  // port parked: clock still, deselected, bus holding no meaningful word
  initial begin
    portClk      = 1'b0;
    portSelect_b = 1'b1;
    rdWr         = 1'b1;
    adIn         = 10'h155;
  end

  // whole port clock cycles of 15 ns, inside frames and on their own through reset
  task automatic tick(input int n);
    repeat (n) begin
      #7.5 portClk = 1'b1;
      #7.5 portClk = 1'b0;
    end
  endtask

  // address word then data word, select and direction low
  task automatic writeReg(input logic [9:0] a, input logic [9:0] d);
    portSelect_b = 1'b0;
    rdWr         = 1'b0;
    adIn         = a;
    tick(1);
    adIn         = d;
    tick(1);
    adIn         = ~d;
    portSelect_b = 1'b1;
    rdWr         = 1'b1;
  endtask

  // address loaded with one edge, then turned round; reading needs no clock
  task automatic startRead(input logic [9:0] a);
    portSelect_b = 1'b0;
    rdWr         = 1'b0;
    adIn         = a;
    tick(1);
    adIn         = ~a;
    rdWr         = 1'b1;
  endtask

  // one turnaround edge with direction high re-arms the address phase, then deselects
  task automatic endRead();
    tick(1);
    portSelect_b = 1'b1;
  endtask
endmodule
